//--- logic/cae_pkg.sv
// Constants, opcodes and state types of the arithmetic and branch execution unit
// What this block does
// - I/O bit operations only for addresses 0x00-0x1F
// - I/O bit set/clear touches only addressed bit
// - Byte add, optional carry: 1 cycle, ZCNVH
// - Word immediate add/subtract: 2 cycles, ZCNVS
// - Byte subtract, optional carry: 1 cycle, ZCNVH
// - AND, OR, XOR: 1 cycle, ZNV only
// - Invert gives 0xFF minus value, ZCNV
// - Negate gives 0x00 minus value, ZCNVH
// - Increment/decrement: 1 cycle, ZNV, carry kept
// - Set/clear bits by mask: 1 cycle, ZNV
// - Test keeps value, clear gives zero, ZNV
// - Relative jump/call: PC+k+1, 2/3 cycles
// - Pointer jump/call: PC from high byte and source operand, 2/3 cycles
// - Equal compare skips next, 1/2/3 cycles, no flags
// - Compares subtract without storing, ZNVCH, 1 cycle
package cae_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_OPA = 8'h00;  // Destination operand / I/O address
  localparam logic [7:0] ADDR_OPB = 8'h01;  // Source operand, constant, bit number
  localparam logic [7:0] ADDR_OPH = 8'h02;  // High byte / offset high / skip size
  localparam logic [7:0] ADDR_CMD = 8'h03;  // Opcode, a write issues it
  localparam logic [7:0] ADDR_FLG = 8'h04;  // Status flags
  localparam logic [7:0] ADDR_RSL = 8'h05;  // Result low byte
  localparam logic [7:0] ADDR_RSH = 8'h06;  // Result high byte
  localparam logic [7:0] ADDR_PCL = 8'h07;  // Program counter low
  localparam logic [7:0] ADDR_PCH = 8'h08;  // Program counter high
  localparam logic [7:0] ADDR_STA = 8'h09;  // Busy, skip, range error
  localparam logic [2:0] IO_WIN = 3'h1;     // Address bits [7:5] of the I/O window
  // ----------------------------------------
  // Flag and status bit positions
  // ----------------------------------------
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int ST_BUSY = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_IOERR = 2;
  // Flag update masks per instruction group
  localparam logic [5:0] M_ZCNVH = 6'h2f;
  localparam logic [5:0] M_ZCNVS = 6'h1f;
  localparam logic [5:0] M_ZCNV = 6'h0f;
  localparam logic [5:0] M_ZNV = 6'h0e;
  localparam logic [5:0] M_NONE = 6'h00;
  // ----------------------------------------
  // Reset values and cycle counts (minus one)
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [1:0] CYC_1 = 2'h0;
  localparam logic [1:0] CYC_2 = 2'h1;
  localparam logic [1:0] CYC_3 = 2'h2;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] SIGNED_MIN = 8'h80;
  localparam logic [7:0] POS_MAX = 8'h7f;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_SUM = 6'b000000, OP_SUM_CARRY = 6'b000001, OP_WORD_IMMEDIATE_SUM = 6'b000010,
    OP_DIFFERENCE = 6'b000011, OP_DIFFERENCE_CONST = 6'b000100,
    OP_DIFF_WITH_CARRY = 6'b000101, OP_DIFF_CARRY_CONST = 6'b000110,
    OP_WORD_IMMEDIATE_DIFF = 6'b000111, OP_CONJUNCTION = 6'b001000,
    OP_CONJUNCTION_CONST = 6'b001001, OP_DISJUNCTION = 6'b001010,
    OP_DISJUNCTION_CONST = 6'b001011, OP_EXCLUSIVE_DISJUNCTION = 6'b001100,
    OP_BIT_INVERT = 6'b001101, OP_ARITHMETIC_INVERT = 6'b001110,
    OP_SET_BITS_IMM = 6'b001111, OP_CLEAR_BITS_IMM = 6'b010000,
    OP_PLUS_ONE = 6'b010001, OP_MINUS_ONE = 6'b010010, OP_ZERO_SIGN_CHECK = 6'b010011,
    OP_ZERO_REGISTER = 6'b010100, OP_ALL_ONES_LOAD = 6'b010101,
    OP_RELATIVE_JUMP = 6'b010110, OP_POINTER_JUMP = 6'b010111,
    OP_RELATIVE_CALL = 6'b011000, OP_POINTER_CALL = 6'b011001,
    OP_EQUAL_SKIP_COMPARE = 6'b011010, OP_COMPARE_REGS = 6'b011011,
    OP_COMPARE_CARRY_REGS = 6'b011100, OP_COMPARE_IMMEDIATE = 6'b011101,
    OP_IO_BIT_SET = 6'b011110, OP_IO_BIT_CLEAR = 6'b011111,
    OP_IO_BIT_TEST_SKIP_IF_ONE = 6'b100000, OP_IO_BIT_TEST_SKIP_IF_ZERO = 6'b100001
  } cae_op_e;
  // Issue state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } cae_state_e;
endpackage

//--- logic/cae_exec.sv
// Execution unit for arithmetic, logic, compare, branch and I/O bit commands
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cae_exec (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Status
  output logic busy_out
);
  import cae_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cae_state_e st;          // Idle or holding off
    logic [1:0] cnt;         // Remaining hold cycles
    logic [7:0] opa;         // Destination operand
    logic [7:0] opb;         // Source operand or constant
    logic [7:0] oph;         // High byte
    logic [5:0] flg;         // Status flags
    logic [15:0] res;        // Result word
    logic [15:0] pc;         // Program counter
    logic skip;              // Last skip taken
    logic ioerr;             // Sticky out-of-range bit access
    logic [31:0][7:0] io;    // Bit-addressable I/O registers
    logic [7:0] rdata;       // Read data, one cycle after strobe
  } cae_state_s;

  cae_state_s state_r;
  cae_state_s state_nxt;

  // ----------------------------------------
  // Arithmetic helpers, result {h, v, c, r}
  // ----------------------------------------
  function automatic logic [10:0] f_add(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [7:0] r;
    r = a + b + {7'h00, ci};
    f_add = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
             (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
             (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]), r};
  endfunction

  // Borrow out of bit 3 and bit 7 give H and C
  function automatic logic [10:0] f_sub(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [7:0] r;
    r = a - b - {7'h00, ci};
    f_sub = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
             (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
             (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]), r};
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [10:0] ar;       // Helper result
    logic [7:0] r8;        // Byte result
    logic [15:0] w;        // Word operand
    logic [15:0] r16;      // Word result
    logic [15:0] tgt;      // Branch target
    logic [5:0] nf;        // Candidate flags
    logic [5:0] msk;       // Flags that this command writes
    logic wide;            // Word-sized result for Z and N
    logic st8;             // Byte result goes to result register
    logic issue;           // Command accepted this cycle
    logic io_ok;           // I/O address inside bit window
    logic skp;             // Skip condition met
    ar = 11'h000;
    r8 = RST_BYTE;
    w = {state_r.oph, state_r.opa};
    r16 = 16'h0000;
    tgt = state_r.pc + 16'h0001;
    nf = 6'h00;
    msk = M_NONE;
    wide = 1'b0;
    st8 = 1'b0;
    skp = 1'b0;
    state_nxt = state_r;
    state_nxt.rdata = RST_BYTE;
    io_ok = (state_r.opa[7:5] == 3'h0);
    // Command writes while holding off are dropped
    issue = wr_in && (addr_in == ADDR_CMD) && (state_r.st == ST_IDLE);

    // Hold-off countdown
    case (state_r.st)
      ST_IDLE: begin
        state_nxt.cnt = CYC_1;
      end
      ST_HOLD: begin
        state_nxt.cnt = state_r.cnt - 2'h1;
        if (state_r.cnt == 2'h1) begin
          state_nxt.st = ST_IDLE;
        end
      end
      default: begin
        state_nxt.st = ST_IDLE;
      end
    endcase

    // Plain register writes
    if (wr_in) begin
      case (addr_in)
        ADDR_OPA: state_nxt.opa = wdata_in;
        ADDR_OPB: state_nxt.opb = wdata_in;
        ADDR_OPH: state_nxt.oph = wdata_in;
        ADDR_FLG: state_nxt.flg = wdata_in[5:0];
        ADDR_PCL: state_nxt.pc[7:0] = wdata_in;
        ADDR_PCH: state_nxt.pc[15:8] = wdata_in;
        // Write one clears the range error
        ADDR_STA: state_nxt.ioerr = state_r.ioerr & ~wdata_in[ST_IOERR];
        default: begin
          if (addr_in[7:5] == IO_WIN) begin
            state_nxt.io[addr_in[4:0]] = wdata_in;
          end
        end
      endcase
    end

    // Command execution; operands are the values before this cycle's writes
    if (issue) begin
      state_nxt.pc = state_r.pc + 16'h0001;
      state_nxt.skip = 1'b0;
      state_nxt.cnt = CYC_1;
      case (wdata_in[5:0])
        OP_SUM, OP_SUM_CARRY: begin
          ar = f_add(state_r.opa, state_r.opb,
                     (wdata_in[5:0] == OP_SUM_CARRY) & state_r.flg[F_C]);
          msk = M_ZCNVH;
          st8 = 1'b1;
        end
        OP_DIFFERENCE, OP_DIFFERENCE_CONST, OP_DIFF_WITH_CARRY, OP_DIFF_CARRY_CONST: begin
          ar = f_sub(state_r.opa, state_r.opb,
                     ((wdata_in[5:0] == OP_DIFF_WITH_CARRY) |
                      (wdata_in[5:0] == OP_DIFF_CARRY_CONST)) & state_r.flg[F_C]);
          msk = M_ZCNVH;
          st8 = 1'b1;
        end
        OP_COMPARE_REGS, OP_COMPARE_CARRY_REGS, OP_COMPARE_IMMEDIATE: begin
          // Flags only, the difference is discarded
          ar = f_sub(state_r.opa, state_r.opb,
                     (wdata_in[5:0] == OP_COMPARE_CARRY_REGS) & state_r.flg[F_C]);
          msk = M_ZCNVH;
        end
        OP_WORD_IMMEDIATE_SUM: begin
          r16 = w + {8'h00, state_r.opb};
          nf[F_C] = ~r16[15] & w[15];
          nf[F_V] = ~w[15] & r16[15];
          msk = M_ZCNVS;
          wide = 1'b1;
          state_nxt.cnt = CYC_2;
        end
        OP_WORD_IMMEDIATE_DIFF: begin
          r16 = w - {8'h00, state_r.opb};
          nf[F_C] = r16[15] & ~w[15];
          nf[F_V] = w[15] & ~r16[15];
          msk = M_ZCNVS;
          wide = 1'b1;
          state_nxt.cnt = CYC_2;
        end
        // Logic group clears V and leaves C alone
        OP_CONJUNCTION, OP_CONJUNCTION_CONST: begin
          ar = {3'h0, state_r.opa & state_r.opb};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_DISJUNCTION, OP_DISJUNCTION_CONST, OP_SET_BITS_IMM: begin
          ar = {3'h0, state_r.opa | state_r.opb};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_CLEAR_BITS_IMM: begin
          ar = {3'h0, state_r.opa & (ALL_ONES - state_r.opb)};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_EXCLUSIVE_DISJUNCTION: begin
          ar = {3'h0, state_r.opa ^ state_r.opb};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_ZERO_SIGN_CHECK: begin
          ar = {3'h0, state_r.opa & state_r.opa};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_ZERO_REGISTER: begin
          ar = {3'h0, state_r.opa ^ state_r.opa};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_BIT_INVERT: begin
          // Carry always set by the inversion
          ar = {3'h1, ALL_ONES - state_r.opa};
          msk = M_ZCNV;
          st8 = 1'b1;
        end
        OP_ARITHMETIC_INVERT: begin
          ar = f_sub(RST_BYTE, state_r.opa, 1'b0);
          msk = M_ZCNVH;
          st8 = 1'b1;
        end
        OP_PLUS_ONE: begin
          ar = {1'b0, state_r.opa == POS_MAX, 1'b0, state_r.opa + 8'h01};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_MINUS_ONE: begin
          ar = {1'b0, state_r.opa == SIGNED_MIN, 1'b0, state_r.opa - 8'h01};
          msk = M_ZNV;
          st8 = 1'b1;
        end
        OP_ALL_ONES_LOAD: begin
          ar = {3'h0, ALL_ONES};
          st8 = 1'b1;
        end
        OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
          // Offset is 12-bit signed, high nibble in the high byte
          tgt = state_r.pc + {{4{state_r.oph[3]}}, state_r.oph[3:0], state_r.opb}
                + 16'h0001;
          state_nxt.pc = tgt;
          state_nxt.cnt = (wdata_in[5:0] == OP_RELATIVE_CALL) ? CYC_3 : CYC_2;
          if (wdata_in[5:0] == OP_RELATIVE_CALL) begin
            state_nxt.res = state_r.pc + 16'h0001;  // Return address
          end
        end
        OP_POINTER_JUMP, OP_POINTER_CALL: begin
          state_nxt.pc = {state_r.oph, state_r.opb};
          state_nxt.cnt = (wdata_in[5:0] == OP_POINTER_CALL) ? CYC_3 : CYC_2;
          if (wdata_in[5:0] == OP_POINTER_CALL) begin
            state_nxt.res = state_r.pc + 16'h0001;
          end
        end
        OP_EQUAL_SKIP_COMPARE: begin
          skp = (state_r.opa == state_r.opb);
        end
        OP_IO_BIT_TEST_SKIP_IF_ONE, OP_IO_BIT_TEST_SKIP_IF_ZERO: begin
          if (io_ok) begin
            skp = state_r.io[state_r.opa[4:0]][state_r.opb[2:0]]
                  ^ (wdata_in[5:0] == OP_IO_BIT_TEST_SKIP_IF_ZERO);
          end else begin
            state_nxt.ioerr = 1'b1;
          end
        end
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
          state_nxt.cnt = CYC_2;
          if (io_ok) begin
            // Only the addressed bit is written, neighbours keep pending flags
            state_nxt.io[state_r.opa[4:0]][state_r.opb[2:0]] =
              (wdata_in[5:0] == OP_IO_BIT_SET);
          end else begin
            state_nxt.ioerr = 1'b1;
          end
        end
        default: begin
          // Unknown opcode acts as a one-cycle no-op
        end
      endcase

      // Skip past one or two words, one hold cycle per skipped word
      if (skp) begin
        state_nxt.skip = 1'b1;
        state_nxt.pc = state_r.pc + (state_r.oph[0] ? 16'h0003 : 16'h0002);
        state_nxt.cnt = state_r.oph[0] ? CYC_3 : CYC_2;
      end

      // Flag formation
      if (wide) begin
        state_nxt.res = r16;
        nf[F_Z] = (r16 == 16'h0000);
        nf[F_N] = r16[15];
      end else begin
        r8 = ar[7:0];
        nf[F_Z] = (r8 == RST_BYTE);
        nf[F_N] = r8[7];
        nf[F_C] = ar[8];
        nf[F_V] = ar[9];
        nf[F_H] = ar[10];
        if (st8) begin
          state_nxt.res = {8'h00, r8};
          state_nxt.opa = r8;
        end
      end
      nf[F_S] = nf[F_N] ^ nf[F_V];
      state_nxt.flg = (state_r.flg & ~msk) | (nf & msk);
      if (state_nxt.cnt != CYC_1) begin
        state_nxt.st = ST_HOLD;
      end
    end

    // Read mux, data valid in the next cycle only
    if (rd_in) begin
      case (addr_in)
        ADDR_OPA: state_nxt.rdata = state_r.opa;
        ADDR_OPB: state_nxt.rdata = state_r.opb;
        ADDR_OPH: state_nxt.rdata = state_r.oph;
        ADDR_FLG: state_nxt.rdata = {2'h0, state_r.flg};
        ADDR_RSL: state_nxt.rdata = state_r.res[7:0];
        ADDR_RSH: state_nxt.rdata = state_r.res[15:8];
        ADDR_PCL: state_nxt.rdata = state_r.pc[7:0];
        ADDR_PCH: state_nxt.rdata = state_r.pc[15:8];
        ADDR_STA: state_nxt.rdata = {5'h00, state_r.ioerr, state_r.skip,
                                     state_r.st == ST_HOLD};
        default: begin
          if (addr_in[7:5] == IO_WIN) begin
            state_nxt.rdata = state_r.io[addr_in[4:0]];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  assign rdata_out = state_r.rdata;
  assign busy_out = (state_r.st == ST_HOLD);
endmodule

//--- test/cae_exec_assertions.sv
// Concurrent checks on the execution unit ports, bound to the unit
`timescale 1ns/1ps
module cae_exec_assertions
  import cae_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Status
  input wire logic busy_out
);
  // ----------------------------------------
  // Helper decode
  // ----------------------------------------
  logic issue;  // Command taken at this edge
  logic [5:0] op;  // Opcode on the write data
  logic [3:0] busy_run_r;  // Length of the current busy run
  assign issue = wr_in && (addr_in == ADDR_CMD) && !busy_out;
  assign op = wdata_in[5:0];
  // Saturating, so a stuck busy cannot wrap back under the limit
  always_ff @(posedge clk_in) begin
    if (reset_in || !busy_out) begin
      busy_run_r <= 4'h0;
    end else if (busy_run_r != 4'hf) begin
      busy_run_r <= busy_run_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ----------------------------------------
  // Cycle counts per command group
  // ----------------------------------------
  // Byte arithmetic, logic and compares finish at once
  AST_BYTE_ONE: assert property (
    issue && op inside {[6'h00:6'h01], [6'h03:6'h06], [6'h08:6'h15], [6'h1b:6'h1d]}
    |=> !busy_out) else $error("byte command held the unit busy");
  AST_WORD_TWO: assert property (
    issue && op inside {OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFF}
    |=> busy_out ##1 !busy_out) else $error("word command not two cycles");
  AST_JUMP_TWO: assert property (
    issue && op inside {OP_RELATIVE_JUMP, OP_POINTER_JUMP}
    |=> busy_out ##1 !busy_out) else $error("jump not two cycles");
  AST_CALL_THREE: assert property (
    issue && op inside {OP_RELATIVE_CALL, OP_POINTER_CALL}
    |=> busy_out [*2] ##1 !busy_out) else $error("call not three cycles");
  AST_SKIP_BOUND: assert property (
    issue && op inside {OP_EQUAL_SKIP_COMPARE, 6'h20, 6'h21}
    |-> ##[1:3] !busy_out) else $error("skip ran past three cycles");
  AST_UNKNOWN_ONE: assert property (
    issue && op > 6'h21 |=> !busy_out) else $error("unknown opcode held busy");
  // ----------------------------------------
  // Hold-off and quiet addresses
  // ----------------------------------------
  AST_BUSY_CAUSE: assert property (
    $rose(busy_out) |-> $past(issue)) else $error("busy rose without a command");
  AST_BUSY_RUN: assert property (
    busy_run_r <= 4'h2) else $error("busy held longer than two cycles");
  AST_IO_OUTSIDE: assert property (
    rd_in && (addr_in inside {[8'h0a:8'h1f], [8'h40:8'hff]}) |=> rdata_out == 8'h00)
    else $error("unmapped address read nonzero");
  // Main scenarios seen
  cover property (issue && op == OP_RELATIVE_CALL);
  cover property (issue && op == OP_WORD_IMMEDIATE_DIFF);
  cover property (busy_out && wr_in && addr_in == ADDR_CMD);
endmodule

bind cae_exec cae_exec_assertions u_cae_chk (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .busy_out(busy_out)
);

//--- test/tb_top.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module tb_top;
  import cae_pkg::*;
  // ----------------------------------------
  // Signals, tallies and case tables
  // ----------------------------------------
  logic clk_in;
  logic reset_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [7:0] rdata_out;
  logic busy_out;
  int fails;
  int checks_done;
  int i;
  logic [7:0] rv;  // Last read value
  logic [47:0] alu_tab [25];  // Op, dest, src, flags in, result, flags out
  logic [63:0] wrd_tab [4];  // Op, high, low, const, flags in, result, flags out
  logic [63:0] br_tab [4];  // Op, high, low, new PC, return, cycles
  logic [47:0] sk_tab [7];  // Op, dest, src, size, cycles, new PC low

  cae_exec uut (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .busy_out(busy_out)
  );

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe left high so writes may follow back to back
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus_rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask
  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic opnd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] h);
    bus_wr(ADDR_OPA, a);
    bus_wr(ADDR_OPB, b);
    bus_wr(ADDR_OPH, h);
  endtask
  // Issue a command and count its cycles, issue cycle included; zero skips the count check
  task automatic cmd(input logic [5:0] op, input int cyc);
    int n;
    n = 1;
    bus_wr(ADDR_CMD, {2'h0, op});
    wr_in <= 1'b0;
    @(negedge clk_in);
    while (busy_out !== 1'b0) begin
      n++;
      if (n > 8) begin
        fails++;
        stop_test();
      end
      @(negedge clk_in);
    end
    if (cyc != 0) chk(16'(n), 16'(cyc));
    @(posedge clk_in);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    checks_done = 0;
    reset_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    alu_tab = '{48'h000f01001020, 48'h00808000000b, 48'h017f0001802c, 48'h03000100ff25,
      48'h048001017f28, 48'h05050501ff25, 48'h06100f000120, 48'h08f00f3f0033,
      48'h09ff80008004, 48'h0a0000080002, 48'h0b0180008104, 48'h0caa5501ff05,
      48'h0d000000ff05, 48'h0e010000ff25, 48'h0f0180008104, 48'h10ff0f00f004,
      48'h117f0001800d, 48'h128000007f08, 48'h120100010003, 48'h138000088004,
      48'h145a00000002, 48'h1512002fff2f, 48'h1b1020001005, 48'h1c201f012022,
      48'h1d8001008028};
    wrd_tab = '{64'h0200ff0120010020, 64'h0700000100ffff15, 64'h027fff010080000c,
      64'h02ffff0100000003};
    br_tab = '{64'h160ffe00ff000002, 64'h1807ff08ff010003, 64'h1712341234000002,
      64'h19beefbeef123503};
    sk_tab = '{48'h1a3333000202, 48'h1a3333010303, 48'h1a3334000101, 48'h200507000202,
      48'h210507010101, 48'h210504010303, 48'h200500000101};
    do_reset();
    // Cleared state, unmapped and write-only places read zero
    rd_chk(ADDR_FLG, 8'h00);
    rd_chk(ADDR_PCL, 8'h00);
    rd_chk(ADDR_STA, 8'h00);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h40, 8'h00);
    rd_chk(ADDR_CMD, 8'h00);
    // Byte arithmetic, logic and compares
    for (i = 0; i < 25; i++) begin
      bus_wr(ADDR_OPA, alu_tab[i][39:32]);
      bus_wr(ADDR_OPB, alu_tab[i][31:24]);
      bus_wr(ADDR_FLG, alu_tab[i][23:16]);
      cmd(alu_tab[i][45:40], 1);
      rd_chk(ADDR_OPA, alu_tab[i][15:8]);
      rd_chk(ADDR_FLG, alu_tab[i][7:0]);
    end
    // Word immediate sum and difference
    for (i = 0; i < 4; i++) begin
      opnd(wrd_tab[i][47:40], wrd_tab[i][39:32], wrd_tab[i][55:48]);
      bus_wr(ADDR_FLG, wrd_tab[i][31:24]);
      cmd(wrd_tab[i][61:56], 2);
      rd_chk(ADDR_RSL, wrd_tab[i][15:8]);
      rd_chk(ADDR_RSH, wrd_tab[i][23:16]);
      rd_chk(ADDR_FLG, wrd_tab[i][7:0]);
    end
    // Jumps and calls chained from one start address, flags untouched
    bus_wr(ADDR_PCL, 8'h00);
    bus_wr(ADDR_PCH, 8'h01);
    bus_wr(ADDR_FLG, 8'h15);
    for (i = 0; i < 4; i++) begin
      opnd(8'h00, br_tab[i][47:40], br_tab[i][55:48]);
      cmd(br_tab[i][61:56], int'(br_tab[i][7:0]));
      rd_chk(ADDR_PCL, br_tab[i][31:24]);
      rd_chk(ADDR_PCH, br_tab[i][39:32]);
      if (br_tab[i][7:0] == 8'h03) begin
        rd_chk(ADDR_RSL, br_tab[i][15:8]);
        rd_chk(ADDR_RSH, br_tab[i][23:16]);
      end
    end
    rd_chk(ADDR_FLG, 8'h15);
    // A command written while busy is dropped
    opnd(8'h10, 8'h00, 8'h00);
    bus_wr(ADDR_PCL, 8'h00);
    bus_wr(ADDR_CMD, {2'h0, OP_RELATIVE_JUMP});
    bus_wr(ADDR_CMD, {2'h0, OP_PLUS_ONE});
    idle(3);
    rd_chk(ADDR_OPA, 8'h10);
    rd_chk(ADDR_PCL, 8'h01);
    cmd(6'h3f, 1);
    rd_chk(ADDR_PCL, 8'h02);
    // I/O bit set and clear, window edge and out-of-range refusal
    bus_wr(8'h25, 8'ha5);
    opnd(8'h05, 8'h06, 8'h00);
    cmd(OP_IO_BIT_SET, 2);
    rd_chk(8'h25, 8'he5);
    bus_wr(ADDR_OPB, 8'h00);
    cmd(OP_IO_BIT_CLEAR, 2);
    rd_chk(8'h25, 8'he4);
    bus_wr(ADDR_OPA, 8'h1f);
    cmd(OP_IO_BIT_SET, 2);
    rd_chk(8'h3f, 8'h01);
    bus_wr(ADDR_OPA, 8'h20);
    cmd(OP_IO_BIT_SET, 0);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h3f, 8'h01);
    bus_rd(ADDR_STA, rv);
    chk({8'h00, rv & 8'h04}, 16'h0004);
    bus_wr(ADDR_STA, 8'h04);
    bus_rd(ADDR_STA, rv);
    chk({8'h00, rv & 8'h04}, 16'h0000);
    // Equal compare and I/O bit skips, both instruction sizes
    bus_wr(ADDR_FLG, 8'h2f);
    for (i = 0; i < 7; i++) begin
      bus_wr(ADDR_PCL, 8'h00);
      bus_wr(ADDR_PCH, 8'h00);
      opnd(sk_tab[i][39:32], sk_tab[i][31:24], sk_tab[i][23:16]);
      cmd(sk_tab[i][45:40], int'(sk_tab[i][15:8]));
      rd_chk(ADDR_PCL, sk_tab[i][7:0]);
      rd_chk(ADDR_STA, {6'h00, sk_tab[i][15:8] != 8'h01, 1'b0});
    end
    rd_chk(ADDR_FLG, 8'h2f);
    // Reset again in mid-run clears everything
    do_reset();
    rd_chk(8'h25, 8'h00);
    rd_chk(ADDR_FLG, 8'h00);
    stop_test();
  end
endmodule
